// ===== rtl/adcctl_pkg.sv
// package of constants for the converter control block
// ==============================================================
package adcctl_pkg;
   // register word offsets (not byte addresses)
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_CONFIG = 4'h1;
   localparam logic [3:0] OFS_TRIGGER = 4'h2;
   localparam logic [3:0] OFS_RES_HIGH = 4'h3;
   localparam logic [3:0] OFS_RES_LOW = 4'h4;
   localparam logic [3:0] OFS_IRQ_STATUS = 4'h5;
   localparam logic [3:0] OFS_IRQ_ENABLE = 4'h6;
   localparam logic [3:0] OFS_IRQ_CLEAR = 4'h7;
   // control register fields
   localparam int BIT_ENABLE = 0;
   localparam int BIT_GO = 1;
   // config register fields
   localparam int BIT_JUSTIFY = 7;
   localparam int POS_CLKSEL = 4;
   localparam int BIT_NEGREF = 2;
   localparam int POS_POSREF = 0;
   localparam logic [7:0] CONFIG_WMASK = 8'hF7;
   localparam logic [7:0] TRIGGER_WMASK = 8'h0F;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] TRIGGER_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // index of the last converter clock period; a conversion spans 12 periods
   localparam logic [3:0] CONV_TICKS = 4'hB;
   // rc clock divide from system clock (free choice)
   localparam logic [6:0] RC_DIV = 7'h28;
   typedef enum logic [1:0] {
      ADCCTL_IDLE,
      ADCCTL_RUN,
      ADCCTL_DONE
   } adcctl_state_type;
endpackage

// ===== rtl/adcctl_top.sv
// converter control: registers, clock divider, trigger, result format
`timescale 1ns/1ps
module adcctl_top (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   // avalon-mm slave
   input wire logic [3:0] I_ADDRESS,
   input wire logic I_READ,
   input wire logic I_WRITE,
   input wire logic [31:0] I_WRITEDATA,
   output logic [31:0] O_READDATA,
   output logic O_WAITREQUEST,
   // trigger sources, index = trigger code
   input wire logic [15:1] I_TRIG_SRC,
   // converter core
   input wire logic [9:0] I_CORE_RESULT,
   output logic O_CORE_POWER,
   output logic O_MUX_CONNECT,
   output logic O_SAMPLE_START,
   output logic O_CONV_CLK_EN,
   output logic O_NEG_REF_EXT,
   output logic [1:0] O_POS_REF_SEL,
   // interrupt
   output logic O_IRQ
);

   // ==============================================================
   // register storage
   logic [7:0] control;
   logic [7:0] config_reg;
   logic [7:0] trigger_sel;
   logic [7:0] result_high_reg;
   logic [7:0] result_low_reg;
   logic irq_status;
   logic irq_enable;
   logic ack;
   logic wr_hit;
   logic rd_hit;
   adcctl_pkg::adcctl_state_type state;
   logic [6:0] div_cnt;
   logic [6:0] div_limit;
   logic tick;
   logic [3:0] tick_cnt;
   logic trig_prev;
   logic trig_now;
   logic trig_edge;
   logic start;
   logic done;
   logic clear_hit;

   // one-cycle wait then acknowledge
   assign O_WAITREQUEST = (I_READ | I_WRITE) & ~ack;
   assign wr_hit = I_WRITE & ack;
   assign rd_hit = I_READ & ~ack;

   // acknowledge flag
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         ack <= 1'b0;
      end else begin
         ack <= (I_READ | I_WRITE) & ~ack;
      end
   end

   // ==============================================================
   // conversion clock divider
   function automatic logic [6:0] div_of(input logic [2:0] sel);
      case (sel)
         3'h0: div_of = 7'h02;
         3'h1: div_of = 7'h08;
         3'h2: div_of = 7'h20;
         3'h4: div_of = 7'h04;
         3'h5: div_of = 7'h10;
         3'h6: div_of = 7'h40;
         default: div_of = adcctl_pkg::RC_DIV; // codes 3 and 7: rc clock
      endcase
   endfunction

   assign div_limit = div_of(config_reg[adcctl_pkg::POS_CLKSEL +: 3]);
   assign tick = (div_cnt == div_limit - 7'h01);
   assign O_CONV_CLK_EN = tick & (state == adcctl_pkg::ADCCTL_RUN);

   // divider counter, runs only while converting
   // a smaller divider chosen mid-conversion lets the count run to wrap: change it only while idle
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         div_cnt <= 7'h00;
      end else if (state != adcctl_pkg::ADCCTL_RUN || tick) begin
         div_cnt <= 7'h00;
      end else begin
         div_cnt <= div_cnt + 7'h01;
      end
   end

   // ==============================================================
   // auto trigger
   assign trig_now = (trigger_sel[3:0] == 4'h0) ? 1'b0 : I_TRIG_SRC[trigger_sel[3:0]];
   assign trig_edge = trig_now & ~trig_prev;

   // previous trigger level
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         trig_prev <= 1'b0;
      end else begin
         trig_prev <= trig_now;
      end
   end

   assign start = control[adcctl_pkg::BIT_ENABLE] & (state == adcctl_pkg::ADCCTL_IDLE) &
                  (trig_edge | (wr_hit && I_ADDRESS == adcctl_pkg::OFS_CONTROL &&
                   I_WRITEDATA[adcctl_pkg::BIT_GO]));
   assign done = (state == adcctl_pkg::ADCCTL_RUN) && tick && tick_cnt == adcctl_pkg::CONV_TICKS;
   assign O_SAMPLE_START = start;

   // ==============================================================
   // conversion sequencer
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         state <= adcctl_pkg::ADCCTL_IDLE;
         tick_cnt <= 4'h0;
      end else begin
         case (state)
            adcctl_pkg::ADCCTL_IDLE: begin
               tick_cnt <= 4'h0;
               if (start) begin
                  state <= adcctl_pkg::ADCCTL_RUN;
               end
            end
            adcctl_pkg::ADCCTL_RUN: begin
               if (!control[adcctl_pkg::BIT_ENABLE]) begin
                  state <= adcctl_pkg::ADCCTL_IDLE;
               end else if (done) begin
                  state <= adcctl_pkg::ADCCTL_DONE;
               end else if (tick) begin
                  tick_cnt <= tick_cnt + 4'h1;
               end
            end
            adcctl_pkg::ADCCTL_DONE: state <= adcctl_pkg::ADCCTL_IDLE;
            default: state <= adcctl_pkg::ADCCTL_IDLE;
         endcase
      end
   end

   // ==============================================================
   // control register: enable and go bit
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         control <= adcctl_pkg::CONTROL_RESET;
      end else begin
         if (wr_hit && I_ADDRESS == adcctl_pkg::OFS_CONTROL) begin
            control[adcctl_pkg::BIT_ENABLE] <= I_WRITEDATA[adcctl_pkg::BIT_ENABLE];
         end
         if (start) begin
            control[adcctl_pkg::BIT_GO] <= 1'b1;
         end else if (done || !control[adcctl_pkg::BIT_ENABLE]) begin
            control[adcctl_pkg::BIT_GO] <= 1'b0;
         end
      end
   end

   // config and trigger select registers
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         config_reg <= adcctl_pkg::CONFIG_RESET;
         trigger_sel <= adcctl_pkg::TRIGGER_RESET;
      end else if (wr_hit) begin
         if (I_ADDRESS == adcctl_pkg::OFS_CONFIG) begin
            config_reg <= I_WRITEDATA[7:0] & adcctl_pkg::CONFIG_WMASK;
         end
         if (I_ADDRESS == adcctl_pkg::OFS_TRIGGER) begin
            trigger_sel <= I_WRITEDATA[7:0] & adcctl_pkg::TRIGGER_WMASK;
         end
      end
   end

   // result registers: software writable, loaded at completion
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         result_high_reg <= 8'h00;
         result_low_reg <= 8'h00;
      end else if (done) begin
         if (config_reg[adcctl_pkg::BIT_JUSTIFY]) begin
            result_high_reg <= {6'h00, I_CORE_RESULT[9:8]};
            result_low_reg <= I_CORE_RESULT[7:0];
         end else begin
            result_high_reg <= I_CORE_RESULT[9:2];
            result_low_reg <= {I_CORE_RESULT[1:0], 6'h00};
         end
      end else if (wr_hit) begin
         if (I_ADDRESS == adcctl_pkg::OFS_RES_HIGH) begin
            result_high_reg <= I_WRITEDATA[7:0];
         end
         if (I_ADDRESS == adcctl_pkg::OFS_RES_LOW) begin
            result_low_reg <= I_WRITEDATA[7:0];
         end
      end
   end

   // ==============================================================
   // software clear strobe for the done flag
   assign clear_hit = wr_hit && I_ADDRESS == adcctl_pkg::OFS_IRQ_CLEAR && I_WRITEDATA[0];

   // interrupt status, enable; set wins over clear
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         irq_status <= 1'b0;
         irq_enable <= 1'b0;
      end else begin
         if (done) begin
            irq_status <= 1'b1;
         end else if (clear_hit) begin
            irq_status <= 1'b0;
         end
         if (wr_hit && I_ADDRESS == adcctl_pkg::OFS_IRQ_ENABLE) begin
            irq_enable <= I_WRITEDATA[0];
         end
      end
   end

   assign O_IRQ = irq_status & irq_enable;

   // ==============================================================
   // analogue side controls
   assign O_CORE_POWER = control[adcctl_pkg::BIT_ENABLE];
   assign O_MUX_CONNECT = control[adcctl_pkg::BIT_ENABLE];
   assign O_NEG_REF_EXT = config_reg[adcctl_pkg::BIT_NEGREF];
   assign O_POS_REF_SEL = config_reg[adcctl_pkg::POS_POSREF +: 2];

   // read data register
   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         O_READDATA <= 32'h00000000;
      end else if (rd_hit) begin
         case (I_ADDRESS)
            adcctl_pkg::OFS_CONTROL: O_READDATA <= {24'h000000, control};
            adcctl_pkg::OFS_CONFIG: O_READDATA <= {24'h000000, config_reg};
            adcctl_pkg::OFS_TRIGGER: O_READDATA <= {24'h000000, trigger_sel};
            adcctl_pkg::OFS_RES_HIGH: O_READDATA <= {24'h000000, result_high_reg};
            adcctl_pkg::OFS_RES_LOW: O_READDATA <= {24'h000000, result_low_reg};
            adcctl_pkg::OFS_IRQ_STATUS: O_READDATA <= {31'h00000000, irq_status};
            adcctl_pkg::OFS_IRQ_ENABLE: O_READDATA <= {31'h00000000, irq_enable};
            default: O_READDATA <= 32'h00000000;
         endcase
      end
   end

   // ==============================================================
   // checks
   sequence s_conv_end;
      done ##1 (state == adcctl_pkg::ADCCTL_DONE);
   endsequence

   AST_GO_CLEARS: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      done |=> !control[adcctl_pkg::BIT_GO])
      else $error("go bit not cleared at completion");
   AST_DONE_FLAG: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      s_conv_end |-> irq_status)
      else $error("done flag not set at completion");
   AST_RIGHT_JUST: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (done && config_reg[adcctl_pkg::BIT_JUSTIFY]) |=> result_high_reg[7:2] == 6'h00)
      else $error("right justified high not zero padded");
   AST_LEFT_JUST: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (done && !config_reg[adcctl_pkg::BIT_JUSTIFY]) |=> result_low_reg[5:0] == 6'h00)
      else $error("left justified low not zero padded");
   AST_LEFT_HIGH: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (done && !config_reg[adcctl_pkg::BIT_JUSTIFY]) |=> result_high_reg == $past(I_CORE_RESULT[9:2]))
      else $error("left justified high wrong");
   AST_NO_TRIG: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (trigger_sel[3:0] == 4'h0 && !wr_hit) |-> !start)
      else $error("start with no trigger selected");
   AST_TRIG_HIGH: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      trigger_sel[7:4] == 4'h0)
      else $error("trigger upper nibble set");
   AST_MUX_OFF: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      !control[adcctl_pkg::BIT_ENABLE] |-> !O_MUX_CONNECT && !O_CORE_POWER)
      else $error("mux connected while disabled");
   AST_EDGE_ONLY: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (trig_now && $past(trig_now) && !wr_hit) |-> !start)
      else $error("start on trigger level");

   // ==============================================================
   // checks on formatting, timing, trigger and bus
   sequence s_load_right;
      done && config_reg[adcctl_pkg::BIT_JUSTIFY];
   endsequence
   sequence s_load_left;
      done && !config_reg[adcctl_pkg::BIT_JUSTIFY];
   endsequence
   sequence s_fast_tick;
      (O_CONV_CLK_EN && !done && control[adcctl_pkg::BIT_ENABLE] && !wr_hit &&
       config_reg[adcctl_pkg::POS_CLKSEL +: 3] == 3'h0) ##1 (control[adcctl_pkg::BIT_ENABLE] && !wr_hit);
   endsequence

   // right justified: top two result bits sit low in the high register
   AST_RIGHT_HIGH: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      s_load_right |=> result_high_reg[1:0] == $past(I_CORE_RESULT[9:8]))
      else $error("right justified high bits wrong");
   // right justified: low register holds the low eight bits
   AST_RIGHT_LOW: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      s_load_right |=> result_low_reg == $past(I_CORE_RESULT[7:0]))
      else $error("right justified low wrong");
   // left justified: two lowest result bits sit at the top of low
   AST_LEFT_LOW: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      s_load_left |=> result_low_reg[7:6] == $past(I_CORE_RESULT[1:0]))
      else $error("left justified low bits wrong");
   // divide by two: ticks two cycles apart while nothing changes
   AST_FAST_TICK: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      s_fast_tick |=> O_CONV_CLK_EN)
      else $error("divide by two tick spacing wrong");
   // both rc codes pick the rc clock rate
   AST_RC_CODES: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (config_reg[adcctl_pkg::POS_CLKSEL +: 2] == 2'h3) |-> (div_limit == adcctl_pkg::RC_DIV))
      else $error("rc clock code not decoded");
   // divider rests outside conversions
   AST_CLOCK_STILL: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (state != adcctl_pkg::ADCCTL_RUN) |=> (div_cnt == 7'h00))
      else $error("divider running while idle");
   // go reads one exactly while converting
   AST_GO_BUSY: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      control[adcctl_pkg::BIT_GO] == (state == adcctl_pkg::ADCCTL_RUN))
      else $error("go bit does not follow busy");
   // a start enters the conversion and shows go
   AST_START_RUN: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      start |=> (state == adcctl_pkg::ADCCTL_RUN && control[adcctl_pkg::BIT_GO]))
      else $error("start did not begin a conversion");
   // a disabled converter never starts
   AST_NO_START_OFF: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      !control[adcctl_pkg::BIT_ENABLE] |-> !start)
      else $error("start while disabled");
   // disabling mid-conversion aborts it
   AST_ABORT: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (!control[adcctl_pkg::BIT_ENABLE] && state == adcctl_pkg::ADCCTL_RUN) |=>
      (state == adcctl_pkg::ADCCTL_IDLE && !control[adcctl_pkg::BIT_GO]))
      else $error("disable did not abort");
   // requests while busy are ignored
   AST_BUSY_IGNORE: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (state != adcctl_pkg::ADCCTL_IDLE) |-> !start)
      else $error("start while busy");
   // a start without a bus write needs a rising trigger
   AST_EDGE_START: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (start && !wr_hit) |-> (trig_now && !trig_prev))
      else $error("trigger start without rising edge");
   // sample start is a single cycle pulse
   AST_SAMPLE_ONE: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      O_SAMPLE_START |=> !O_SAMPLE_START)
      else $error("sample start longer than one cycle");
   // trigger code zero selects no source
   AST_TRIG_OFF: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (trigger_sel[3:0] == 4'h0) |-> !trig_now)
      else $error("trigger seen with code zero");
   // done flag holds until cleared
   AST_FLAG_STICKY: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (irq_status && !clear_hit) |=> irq_status)
      else $error("done flag dropped without clear");
   // completion beats a clear in the same cycle
   AST_SET_WINS: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (done && clear_hit) |=> irq_status)
      else $error("clear beat completion");
   // results change only on completion or a write
   AST_RESULT_HOLD: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (!done && !wr_hit) |=> ($stable(result_high_reg) && $stable(result_low_reg)))
      else $error("result changed without cause");
   // exactly one wait cycle per request
   AST_ONE_WAIT: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      ((I_READ || I_WRITE) && O_WAITREQUEST) |=> !O_WAITREQUEST)
      else $error("more than one wait cycle");
   // read data above the byte stays zero
   AST_READ_UPPER: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      O_READDATA[31:8] == 24'h000000)
      else $error("read data upper bits set");
   // trigger register reads zero in its upper nibble
   AST_TRIG_READ: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (rd_hit && I_ADDRESS == adcctl_pkg::OFS_TRIGGER) |=> (O_READDATA[7:4] == 4'h0))
      else $error("trigger read upper nibble set");
   // unimplemented config bit stays zero
   AST_UNIMPL_BIT: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      config_reg[3] == 1'b0)
      else $error("unimplemented config bit set");

endmodule

// ===== verif/adcctl_core_model.sv
// behavioural model of the analogue sampling and conversion core
`timescale 1ns/1ps
module adcctl_core_model (
   // clock
   input wire logic i_clk,
   // control from the block
   input wire logic i_power,
   input wire logic i_start,
   // analogue value to convert
   input wire logic [9:0] i_value,
   // result to the block
   output logic [9:0] o_result
);
   logic [9:0] held = 10'h155;
   // latch the input at sample start; an unpowered core shows garbage
   always_ff @(posedge i_clk) begin
      if (i_start) begin
         held <= i_value;
      end else if (!i_power) begin
         held <= ~held;
      end
   end
   assign o_result = held;
endmodule

// ===== verif/test_adcctl_top.sv
// bench for the converter control block
`timescale 1ns/1ps
module test_adcctl_top;
   logic I_CLK, I_RESET_N, I_READ, I_WRITE, O_WAITREQUEST, O_CORE_POWER, O_MUX_CONNECT;
   logic O_SAMPLE_START, O_CONV_CLK_EN, O_NEG_REF_EXT, O_IRQ;
   logic [3:0] I_ADDRESS;
   logic [31:0] I_WRITEDATA, O_READDATA, rd;
   logic [15:1] I_TRIG_SRC;
   logic [9:0] I_CORE_RESULT, core_value;
   logic [1:0] O_POS_REF_SEL;
   int fail_count = 0;
   int checked = 0;
   int cyc = 0;
   int last_tick = 0;
   int period = 0;
   int starts = 0;
   int divs[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
   // ==============================================================
   // design and core model
   adcctl_top dut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_ADDRESS(I_ADDRESS), .I_READ(I_READ),
      .I_WRITE(I_WRITE), .I_WRITEDATA(I_WRITEDATA), .O_READDATA(O_READDATA), .O_WAITREQUEST(O_WAITREQUEST),
      .I_TRIG_SRC(I_TRIG_SRC), .I_CORE_RESULT(I_CORE_RESULT), .O_CORE_POWER(O_CORE_POWER),
      .O_MUX_CONNECT(O_MUX_CONNECT), .O_SAMPLE_START(O_SAMPLE_START), .O_CONV_CLK_EN(O_CONV_CLK_EN),
      .O_NEG_REF_EXT(O_NEG_REF_EXT), .O_POS_REF_SEL(O_POS_REF_SEL), .O_IRQ(O_IRQ));
   adcctl_core_model core (.i_clk(I_CLK), .i_power(O_CORE_POWER), .i_start(O_SAMPLE_START),
      .i_value(core_value), .o_result(I_CORE_RESULT));
   // ==============================================================
   // clock, start and tick monitor, timeout
   initial begin
      I_CLK = 1'b0;
      forever #2.5 I_CLK = ~I_CLK;
   end
   always @(posedge I_CLK) begin
      cyc <= cyc + 1;
      if (O_SAMPLE_START === 1'b1) begin
         starts <= starts + 1;
      end
      if (O_CONV_CLK_EN === 1'b1) begin
         period <= cyc - last_tick;
         last_tick <= cyc;
      end
      if (cyc == 20000) begin
         fail_count++;
         end_of_test();
      end
   end
   // ==============================================================
   // shared tasks
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge I_CLK);
      I_ADDRESS <= a;
      I_WRITEDATA <= {24'h0, d};
      I_WRITE <= wr;
      I_READ <= ~wr;
      do @(posedge I_CLK); while (O_WAITREQUEST !== 1'b0);
      rd = O_READDATA;
      I_WRITE <= 1'b0;
      I_READ <= 1'b0;
      // let the write land before callers look at outputs
      @(posedge I_CLK);
   endtask
   task automatic wait_idle;
      do bus(1'b0, adcctl_pkg::OFS_CONTROL, 8'h00); while (rd[1] !== 1'b0);
   endtask
   // ==============================================================
   // scenarios
   task automatic s_regs;
      bus(1'b0, adcctl_pkg::OFS_CONFIG, 8'h00);
      check("config reset", 32'h0, rd);
      bus(1'b0, adcctl_pkg::OFS_TRIGGER, 8'h00);
      check("trigger reset", 32'h0, rd);
      bus(1'b1, adcctl_pkg::OFS_CONFIG, 8'hFF);
      bus(1'b0, adcctl_pkg::OFS_CONFIG, 8'h00);
      check("config bit3", 32'hF7, rd);
      check("neg ref", 1'b1, O_NEG_REF_EXT);
      check("pos ref", 2'h3, O_POS_REF_SEL);
      bus(1'b1, adcctl_pkg::OFS_CONFIG, 8'h02);
      check("neg ref", 1'b0, O_NEG_REF_EXT);
      check("pos ref", 2'h2, O_POS_REF_SEL);
      bus(1'b1, adcctl_pkg::OFS_TRIGGER, 8'hFF);
      bus(1'b0, adcctl_pkg::OFS_TRIGGER, 8'h00);
      check("trigger upper", 32'h0F, rd);
      bus(1'b0, 4'hF, 8'h00);
      check("unmapped", 32'h0, rd);
   endtask
   task automatic s_convert(input logic [2:0] cs, input logic j, input logic [9:0] v);
      int exp;
      exp = (divs[cs] == 0) ? int'(adcctl_pkg::RC_DIV) : divs[cs];
      core_value <= v;
      bus(1'b1, adcctl_pkg::OFS_IRQ_ENABLE, {7'h0, cs[0]});
      bus(1'b1, adcctl_pkg::OFS_CONFIG, {j, cs, 4'h0});
      bus(1'b1, adcctl_pkg::OFS_CONTROL, 8'h03);
      bus(1'b0, adcctl_pkg::OFS_CONTROL, 8'h00);
      check("go busy", 1'b1, rd[1]);
      wait_idle();
      check("tick period", exp, period);
      bus(1'b0, adcctl_pkg::OFS_RES_HIGH, 8'h00);
      check("result high", j ? {6'h00, v[9:8]} : v[9:2], rd);
      bus(1'b0, adcctl_pkg::OFS_RES_LOW, 8'h00);
      check("result low", j ? v[7:0] : {v[1:0], 6'h00}, rd);
      bus(1'b0, adcctl_pkg::OFS_IRQ_STATUS, 8'h00);
      check("done flag", 1'b1, rd[0]);
      check("irq level", cs[0], O_IRQ);
      bus(1'b1, adcctl_pkg::OFS_IRQ_CLEAR, 8'h01);
      bus(1'b0, adcctl_pkg::OFS_IRQ_STATUS, 8'h00);
      check("flag cleared", 1'b0, rd[0]);
      check("irq cleared", 1'b0, O_IRQ);
   endtask
   task automatic s_trigger;
      int s0;
      bus(1'b1, adcctl_pkg::OFS_CONFIG, 8'h00);
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, adcctl_pkg::OFS_TRIGGER, c[7:0]);
         s0 = starts;
         I_TRIG_SRC <= (c == 0) ? 15'h7FFF : 15'h7FFF & ~(15'h1 << (c - 1));
         repeat (4) @(posedge I_CLK);
         check("stray start", s0, starts);
         if (c != 0) begin
            I_TRIG_SRC <= 15'h7FFF;
            wait_idle();
            repeat (30) @(posedge I_CLK);
            check("one start", s0 + 1, starts);
         end
         I_TRIG_SRC <= 15'h0;
      end
   endtask
   task automatic s_disable;
      int s0;
      bus(1'b1, adcctl_pkg::OFS_CONTROL, 8'h00);
      check("mux off", 1'b0, O_MUX_CONNECT);
      check("power off", 1'b0, O_CORE_POWER);
      s0 = starts;
      bus(1'b1, adcctl_pkg::OFS_CONTROL, 8'h02);
      repeat (4) @(posedge I_CLK);
      check("go disabled", s0, starts);
      bus(1'b1, adcctl_pkg::OFS_CONTROL, 8'h01);
      check("mux on", 1'b1, O_MUX_CONNECT);
   endtask
   // ==============================================================
   // verdict
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      I_RESET_N = 1'b0;
      I_READ = 1'b0;
      I_WRITE = 1'b0;
      I_ADDRESS = 4'h0;
      I_WRITEDATA = 32'h0;
      I_TRIG_SRC = 15'h0;
      core_value = 10'h0;
      repeat (8) @(posedge I_CLK);
      I_RESET_N <= 1'b1;
      s_regs();
      bus(1'b1, adcctl_pkg::OFS_CONTROL, 8'h01);
      for (int c = 0; c < 8; c++) begin
         s_convert(c[2:0], c[1], 10'h2A5 ^ {c[2:0], 7'h0});
      end
      s_trigger();
      s_disable();
      end_of_test();
   end
endmodule
